// [logic/fol_pkg.sv]
// Package with constants and types for the option-byte loader.
package fol_pkg;

  localparam int unsigned FOL_MEM_BYTES_DEF = 8192;
  localparam int unsigned FOL_PAGE_BYTES    = 512;
  localparam int unsigned FOL_ROW_BYTES     = 64;
  localparam int unsigned FOL_ROWS_PER_PAGE = 8;
  localparam int unsigned FOL_SECT_BIG      = 1024;
  localparam int unsigned FOL_SECT_SMALL    = 512;
  localparam int unsigned FOL_BIG_VARIANT   = 8192;

  localparam logic [15:0] FOL_OPT0_ADDR     = 16'h0000;
  localparam logic [15:0] FOL_OPT1_ADDR     = 16'h0001;
  localparam logic [15:0] FOL_INFO_BASE     = 16'hfe00;
  localparam logic [15:0] FOL_LOT_BYTE0     = 16'hfe7d;
  localparam logic [15:0] FOL_LOT_BYTE23    = 16'hfe5c;
  localparam logic [15:0] FOL_TRIM_ADDR     = 16'hfe02;
  localparam logic [15:0] FOL_CAL_ADDR      = 16'hfe03;

  // Option byte 0 field positions.
  localparam int unsigned FOL_B0_WD_RESET   = 7;
  localparam int unsigned FOL_B0_WD_ALWAYS  = 6;
  localparam int unsigned FOL_B0_BROWN_STOP = 5;
  localparam int unsigned FOL_B0_RD_PROT    = 4;
  localparam int unsigned FOL_B0_WR_ALL     = 3;
  localparam int unsigned FOL_B0_WR_SECT    = 2;

  localparam logic [7:0]  FOL_OPT_RST       = 8'hff;

  localparam logic [2:0]  FOL_CMD_NONE      = 3'h0;
  localparam logic [2:0]  FOL_CMD_READ      = 3'h1;
  localparam logic [2:0]  FOL_CMD_PROG      = 3'h2;
  localparam logic [2:0]  FOL_CMD_ERASE     = 3'h3;

  typedef enum logic [2:0] {
    FOL_ST_IDLE  = 3'b000,
    FOL_ST_RD0   = 3'b001,
    FOL_ST_WT0   = 3'b010,
    FOL_ST_RD1   = 3'b011,
    FOL_ST_WT1   = 3'b100,
    FOL_ST_DONE  = 3'b101
  } fol_state_e;

endpackage : fol_pkg

// [logic/fol_loader.sv]
// Option-byte loader and program-memory access gate for the flash array.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module fol_loader
  import fol_pkg::*;
#(
  parameter int unsigned MEM_BYTES = FOL_MEM_BYTES_DEF
) (
  input  wire logic        clk_in,           // System clock, 250 MHz.
  input  wire logic        rst_n_in,         // Synchronous reset, active low.
  input  wire logic        reload_in,        // Any reset event: system, power-on, stop recovery.
  input  wire logic [15:0] req_addr_in,      // Access address from processor or debug unit.
  input  wire logic [2:0]  req_cmd_in,       // Access command: none, read, program, erase.
  input  wire logic        req_dbg_in,       // Access comes from the on-chip debug unit.
  input  wire logic [7:0]  req_wdata_in,     // Program data.
  input  wire logic [7:0]  fl_rdata_in,      // Flash array read data, one cycle after read.
  output logic             fl_rd_out,        // Flash array read strobe.
  output logic             fl_prog_out,      // Flash array program strobe.
  output logic             fl_erase_out,     // Flash array page erase strobe.
  output logic      [15:0] fl_addr_out,      // Flash array address.
  output logic      [7:0]  fl_wdata_out,     // Flash array program data.
  output logic             req_denied_out,   // Last access was blocked, one cycle pulse.
  output logic      [7:0]  req_rdata_out,    // Read data back to the requester.
  output logic             cpu_rst_n_out,    // Processor reset, low until options loaded.
  output logic             load_done_out,    // Option load complete.
  output logic             wd_reset_sel_out, // Watchdog timeout forces reset when high.
  output logic             wd_always_out,    // Watchdog runs from reset.
  output logic             brown_stop_out,   // Brownout stays enabled in stop mode.
  output logic             rd_prot_out,      // External code reads blocked.
  output logic      [3:0]  page_out,         // Page index of the last access.
  output logic      [2:0]  row_out           // Row index of the last access.
);

  localparam int unsigned SECT_BYTES = (MEM_BYTES == FOL_BIG_VARIANT) ?
                                       FOL_SECT_BIG : FOL_SECT_SMALL;
  localparam int unsigned SECT_SHIFT = $clog2(SECT_BYTES);
  localparam int unsigned PAGE_SHIFT = $clog2(FOL_PAGE_BYTES);
  localparam int unsigned ROW_SHIFT  = $clog2(FOL_ROW_BYTES);
  localparam logic [15:0] ADDR_LIMIT = 16'(MEM_BYTES);

  typedef struct packed {
    fol_state_e  st;
    logic [7:0]  opt0;
    logic [7:0]  opt1;
    logic        rd;
    logic        prog;
    logic        erase;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        denied;
    logic [7:0]  rdata;
    logic        rd_pend;
    logic        cpu_rst_n;
    logic        done;
    logic [3:0]  page;
    logic [2:0]  row;
    logic        wd_always;
    logic        rd_prot;
  } fol_state_s;

  fol_state_s s_reg;
  fol_state_s s_next;

  logic [2:0]  sect_idx;
  logic        sect_lock;
  logic        opt_area;
  logic        user_code;
  logic        is_info;

  always_comb begin
    sect_idx  = 3'(req_addr_in >> SECT_SHIFT);
    // Option byte 1 holds one lock bit per sector, active low, so erased is unlocked.
    sect_lock = !s_reg.opt1[sect_idx] && !s_reg.opt0[FOL_B0_WR_SECT];
    // Trim, calibration and lot bytes all live in the info page and read like any byte.
    is_info   = (req_addr_in[15:8] == FOL_INFO_BASE[15:8]);
    opt_area  = (req_addr_in == FOL_OPT0_ADDR) || (req_addr_in == FOL_OPT1_ADDR);
    user_code = !is_info && (req_addr_in < ADDR_LIMIT);
  end

  always_comb begin
    s_next        = s_reg;
    s_next.rd     = 1'b0;
    s_next.prog   = 1'b0;
    s_next.erase  = 1'b0;
    s_next.denied = 1'b0;
    // Flash data arrive the cycle after the strobe, so capture waits one more edge.
    s_next.rd_pend = s_reg.rd && s_reg.done;
    if (s_reg.rd_pend) begin
      s_next.rdata = fl_rdata_in;
    end
    case (s_reg.st)
      FOL_ST_IDLE: begin
        s_next.st = FOL_ST_RD0;
      end
      FOL_ST_RD0: begin
        s_next.rd   = 1'b1;
        s_next.addr = FOL_OPT0_ADDR;
        s_next.st   = FOL_ST_WT0;
      end
      FOL_ST_WT0: begin
        s_next.st = FOL_ST_RD1;
      end
      FOL_ST_RD1: begin
        s_next.opt0 = fl_rdata_in;
        s_next.rd   = 1'b1;
        s_next.addr = FOL_OPT1_ADDR;
        s_next.st   = FOL_ST_WT1;
      end
      FOL_ST_WT1: begin
        s_next.st = FOL_ST_DONE;
      end
      FOL_ST_DONE: begin
        if (!s_reg.done) begin
          s_next.opt1      = fl_rdata_in;
          s_next.done      = 1'b1;
          s_next.cpu_rst_n = 1'b1;
        end else if (req_cmd_in != FOL_CMD_NONE) begin
          s_next.addr  = req_addr_in;
          s_next.wdata = req_wdata_in;
          s_next.page  = 4'(req_addr_in >> PAGE_SHIFT);
          s_next.row   = 3'(req_addr_in >> ROW_SHIFT);
          if (!user_code && !is_info) begin
            s_next.denied = 1'b1;
          end else if (req_cmd_in == FOL_CMD_READ) begin
            // Read protection only stops the debug unit; running code still fetches.
            if (req_dbg_in && !s_reg.opt0[FOL_B0_RD_PROT] && user_code) begin
              s_next.denied = 1'b1;
            end else begin
              s_next.rd = 1'b1;
            end
          end else if (is_info ||
                       !s_reg.opt0[FOL_B0_WR_ALL] || sect_lock) begin
            s_next.denied = 1'b1;
          end else if (req_cmd_in == FOL_CMD_PROG) begin
            s_next.prog = 1'b1;
          end else if (req_cmd_in == FOL_CMD_ERASE) begin
            // Erase is whole-page only, so the in-page bits are dropped.
            s_next.addr  = {req_addr_in[15:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
            s_next.erase = 1'b1;
          end else begin
            s_next.denied = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = FOL_ST_IDLE;
      end
    endcase
    // A fresh reset event restarts the load; the processor goes back into reset.
    // A request in the cycle of a reset event gets no strobe, but its address, data, page and row are still taken.
    if (reload_in) begin
      s_next.st        = FOL_ST_IDLE;
      s_next.done      = 1'b0;
      s_next.cpu_rst_n = 1'b0;
      s_next.rd        = 1'b0;
      s_next.prog      = 1'b0;
      s_next.erase     = 1'b0;
      s_next.denied    = 1'b0;
    end
    // Active-low option bits are turned into flops so the outputs carry no gate.
    s_next.wd_always = !s_next.opt0[FOL_B0_WD_ALWAYS];
    s_next.rd_prot   = !s_next.opt0[FOL_B0_RD_PROT];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg           <= '0;
      s_reg.st        <= FOL_ST_IDLE;
      s_reg.opt0      <= FOL_OPT_RST;
      s_reg.opt1      <= FOL_OPT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Holding registers have no path to req_rdata_out other than a real flash read.
  assign fl_rd_out        = s_reg.rd;
  assign fl_prog_out      = s_reg.prog;
  assign fl_erase_out     = s_reg.erase;
  assign fl_addr_out      = s_reg.addr;
  assign fl_wdata_out     = s_reg.wdata;
  assign req_denied_out   = s_reg.denied;
  assign req_rdata_out    = s_reg.rdata;
  assign cpu_rst_n_out    = s_reg.cpu_rst_n;
  assign load_done_out    = s_reg.done;
  assign wd_reset_sel_out = s_reg.opt0[FOL_B0_WD_RESET];
  assign wd_always_out    = s_reg.wd_always;
  assign brown_stop_out   = s_reg.opt0[FOL_B0_BROWN_STOP];
  assign rd_prot_out      = s_reg.rd_prot;
  assign page_out         = s_reg.page;
  assign row_out          = s_reg.row;

  a_cpu_held_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !s_reg.done |-> !cpu_rst_n_out)
    else $error("processor released before options loaded");
  a_load_seq_time: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_reg.st == FOL_ST_IDLE && !reload_in) ##1 !reload_in [*5] |=> load_done_out)
    else $error("option load did not finish in six cycles");
  a_first_addr_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (fl_rd_out && s_reg.st == FOL_ST_WT0) |-> fl_addr_out == FOL_OPT0_ADDR)
    else $error("first option read not at zero");
  a_second_addr_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (fl_rd_out && s_reg.st == FOL_ST_WT1) |-> fl_addr_out == FOL_OPT1_ADDR)
    else $error("second option read not at one");
  a_erase_page_align: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fl_erase_out |-> fl_addr_out[PAGE_SHIFT-1:0] == '0)
    else $error("erase address not page aligned");
  a_reload_drops_cpu: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reload_in |=> !cpu_rst_n_out && !load_done_out)
    else $error("reset event did not hold processor");
  a_prot_blocks_dbg: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (load_done_out && !reload_in && req_cmd_in == FOL_CMD_READ && req_dbg_in
     && rd_prot_out && req_addr_in < ADDR_LIMIT) |=> req_denied_out && !fl_rd_out)
    else $error("protected read reached the array");
  a_lock_blocks_prog: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (load_done_out && !reload_in && req_cmd_in != FOL_CMD_NONE
     && req_cmd_in != FOL_CMD_READ && !s_reg.opt0[FOL_B0_WR_ALL])
     |=> !fl_prog_out && !fl_erase_out)
    else $error("program or erase passed a full lock");
  a_opts_stable_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (load_done_out && !reload_in) |=> $stable(wd_reset_sel_out) && $stable(rd_prot_out))
    else $error("options changed without reset");
  a_strobe_onehot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $onehot0({fl_rd_out, fl_prog_out, fl_erase_out}))
    else $error("more than one flash strobe at once");
  a_denied_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    req_denied_out |-> !fl_rd_out && !fl_prog_out && !fl_erase_out)
    else $error("refused access still reached the array");
  a_info_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (load_done_out && !reload_in && req_addr_in[15:8] == FOL_INFO_BASE[15:8]
     && (req_cmd_in == FOL_CMD_PROG || req_cmd_in == FOL_CMD_ERASE))
     |=> !fl_prog_out && !fl_erase_out)
    else $error("info page was programmed or erased");
  a_sect_lock_prog: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (load_done_out && !reload_in && req_cmd_in == FOL_CMD_PROG
     && req_addr_in < ADDR_LIMIT && !s_reg.opt0[FOL_B0_WR_SECT]
     && !s_reg.opt1[3'(req_addr_in >> SECT_SHIFT)]) |=> !fl_prog_out)
    else $error("program passed a sector lock");
  a_no_write_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !load_done_out |=> !fl_prog_out && !fl_erase_out)
    else $error("array written while options loading");
  a_cpu_rel_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(load_done_out) |-> cpu_rst_n_out)
    else $error("processor not released with load done");
  a_page_index: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fl_erase_out |-> page_out == 4'(fl_addr_out >> PAGE_SHIFT))
    else $error("page index does not match erase address");
  a_row_index: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fl_prog_out |-> row_out == 3'(fl_addr_out >> ROW_SHIFT))
    else $error("row index does not match program address");
  a_erase_keeps_page: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fl_erase_out |-> fl_addr_out[15:9] == $past(req_addr_in[15:9]))
    else $error("erase went to the wrong page");
  a_load_opt0: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_reg.st == FOL_ST_RD1 && !reload_in) |=> s_reg.opt0 == $past(fl_rdata_in))
    else $error("option byte zero not taken from flash");
  a_load_opt1: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_reg.st == FOL_ST_DONE && !s_reg.done && !reload_in)
     |=> s_reg.opt1 == $past(fl_rdata_in))
    else $error("option byte one not taken from flash");
  a_read_returns: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (fl_rd_out && load_done_out && !reload_in) ##1 !reload_in
     |=> req_rdata_out == $past(fl_rdata_in))
    else $error("read data not taken in the data cycle");
  a_wd_always_lvl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_done_out |-> wd_always_out == !s_reg.opt0[FOL_B0_WD_ALWAYS])
    else $error("watchdog force does not follow its option");
  a_rd_prot_lvl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_done_out |-> rd_prot_out == !s_reg.opt0[FOL_B0_RD_PROT])
    else $error("read protection does not follow its option");

endmodule : fol_loader
`default_nettype wire

// [verification/fol_flash_model.sv]
// Behavioural flash array facing the option-byte loader.
`timescale 1ns/1ps
`default_nettype none
module fol_flash_model #(
  parameter logic [7:0] OPT0 = 8'hff,
  parameter logic [7:0] OPT1 = 8'hff
) (
  input  wire logic        clk_in,   // System clock.
  input  wire logic        rd_in,    // Read strobe.
  input  wire logic        prog_in,  // Program strobe.
  input  wire logic        erase_in, // Page erase strobe.
  input  wire logic [15:0] addr_in,  // Byte address.
  input  wire logic [7:0]  wdata_in, // Program data.
  output logic      [7:0]  rdata_out // Data, valid only the cycle after a read.
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    mem[0] = OPT0;
    mem[1] = OPT1;
    rdata_out = 8'h00;
  end
  // Data toggle outside the valid cycle so a sample one cycle late sees inverted data, not a stale match.
  always @(posedge clk_in) begin
    rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
    if (prog_in) mem[addr_in] <= mem[addr_in] & wdata_in;
    if (erase_in)
      for (int i = 0; i < 512; i++) mem[{addr_in[15:9], 9'h000} + i] <= 8'hff;
  end
endmodule : fol_flash_model
`default_nettype wire

// [verification/fol_loader_bench.sv]
// Self-checking bench for the option-byte loader.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module fol_loader_bench;
  import fol_pkg::*;
  localparam logic [7:0] OPT0 = 8'hab;
  localparam logic [7:0] OPT1 = 8'hfd;
  logic        clk_in, rst_n_in, reload_in, req_dbg_in, fl_rd_out, fl_prog_out, fl_erase_out;
  logic        req_denied_out, cpu_rst_n_out, load_done_out, wd_reset_sel_out, wd_always_out;
  logic        brown_stop_out, rd_prot_out;
  logic [15:0] req_addr_in, fl_addr_out, a, ldq[$];
  logic [7:0]  req_wdata_in, fl_rdata_in, fl_wdata_out, req_rdata_out;
  logic [2:0]  req_cmd_in, row_out;
  logic [3:0]  page_out;
  int          errors, num_checks, seed;
  logic        d_r;

  fol_loader uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reload_in(reload_in),
    .req_addr_in(req_addr_in), .req_cmd_in(req_cmd_in), .req_dbg_in(req_dbg_in),
    .req_wdata_in(req_wdata_in), .fl_rdata_in(fl_rdata_in), .fl_rd_out(fl_rd_out),
    .fl_prog_out(fl_prog_out), .fl_erase_out(fl_erase_out), .fl_addr_out(fl_addr_out),
    .fl_wdata_out(fl_wdata_out), .req_denied_out(req_denied_out), .req_rdata_out(req_rdata_out),
    .cpu_rst_n_out(cpu_rst_n_out), .load_done_out(load_done_out),
    .wd_reset_sel_out(wd_reset_sel_out), .wd_always_out(wd_always_out),
    .brown_stop_out(brown_stop_out), .rd_prot_out(rd_prot_out), .page_out(page_out),
    .row_out(row_out));
  fol_flash_model #(.OPT0(OPT0), .OPT1(OPT1)) flash (.clk_in(clk_in), .rd_in(fl_rd_out),
    .prog_in(fl_prog_out), .erase_in(fl_erase_out), .addr_in(fl_addr_out),
    .wdata_in(fl_wdata_out), .rdata_out(fl_rdata_in));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (fl_rd_out === 1'b1 && load_done_out === 1'b0) ldq.push_back(fl_addr_out);

  function automatic logic [7:0] pat(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5a;
  endfunction : pat

  task automatic chk_opts(input logic [7:0] o);
    `CHK({wd_reset_sel_out, wd_always_out, brown_stop_out, rd_prot_out}, {o[7], ~o[6], o[5], ~o[4]})
  endtask : chk_opts

  task automatic wait_load();
    for (int i = 0; i < 20 && load_done_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    `CHK(cpu_rst_n_out, 1'b1)
    `CHK(ldq.size(), 2)
    `CHK({ldq[0], ldq[1]}, {FOL_OPT0_ADDR, FOL_OPT1_ADDR})
  endtask : wait_load

  task automatic reload();
    ldq.delete();
    @(posedge clk_in);
    reload_in <= 1'b1;
    @(posedge clk_in);
    reload_in <= 1'b0;
    #1;
    `CHK(cpu_rst_n_out, 1'b0)
    wait_load();
  endtask : reload

  task automatic acc(input logic [2:0] c, input logic [15:0] ad, input logic d,
                     input logic [7:0] w, input logic den, input logic [7:0] exp);
    @(posedge clk_in);
    req_cmd_in <= c;
    req_addr_in <= ad;
    req_dbg_in <= d;
    req_wdata_in <= w;
    @(posedge clk_in);
    req_cmd_in <= FOL_CMD_NONE;
    #1;
    `CHK(req_denied_out, den)
    `CHK({fl_rd_out, fl_prog_out, fl_erase_out}, den ? 3'b000 : 3'b100 >> (c - 3'h1))
    if (!den) `CHK(fl_addr_out, c == FOL_CMD_ERASE ? {ad[15:9], 9'h000} : ad)
    if (!den && ad < 16'h2000) `CHK({page_out, row_out}, {ad[12:9], ad[8:6]})
    if (!den && c == FOL_CMD_READ) begin
      repeat (2) @(posedge clk_in);
      #1;
      `CHK(req_rdata_out, exp)
    end
  endtask : acc

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    #20000;
    errors++;
    complete_run();
  end

  initial begin
    seed = 88517;
    {rst_n_in, reload_in, req_dbg_in, req_cmd_in, req_addr_in, req_wdata_in} = '0;
    repeat (4) @(posedge clk_in);
    #1;
    `CHK(cpu_rst_n_out, 1'b0)
    chk_opts(8'hff);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    wait_load();
    chk_opts(OPT0);
    $display("test reset load done");
    // Protection is on, so debug reads of user code must be refused.
    repeat (24) begin
      a = (16'($random(seed)) & 16'h1fff) | 16'h0100;
      d_r = 1'($random(seed));
      acc(FOL_CMD_READ, a, d_r, 8'h00, d_r, pat(a));
    end
    acc(FOL_CMD_READ, FOL_LOT_BYTE0, 1'b0, 8'h00, 1'b0, pat(FOL_LOT_BYTE0));
    acc(FOL_CMD_READ, FOL_LOT_BYTE23, 1'b0, 8'h00, 1'b0, pat(FOL_LOT_BYTE23));
    acc(FOL_CMD_READ, FOL_TRIM_ADDR, 1'b0, 8'h00, 1'b0, pat(FOL_TRIM_ADDR));
    acc(FOL_CMD_READ, FOL_CAL_ADDR, 1'b0, 8'h00, 1'b0, pat(FOL_CAL_ADDR));
    acc(FOL_CMD_READ, 16'h2000, 1'b0, 8'h00, 1'b1, 8'h00);
    acc(FOL_CMD_PROG, 16'h0500, 1'b0, 8'h00, 1'b1, 8'h00);
    acc(FOL_CMD_PROG, FOL_TRIM_ADDR, 1'b0, 8'h00, 1'b1, 8'h00);
    acc(FOL_CMD_PROG, 16'h0800, 1'b1, 8'h0f, 1'b0, 8'h00);
    acc(FOL_CMD_READ, 16'h0800, 1'b0, 8'h00, 1'b0, pat(16'h0800) & 8'h0f);
    acc(FOL_CMD_ERASE, 16'h0123, 1'b0, 8'h00, 1'b0, 8'h00);
    acc(FOL_CMD_READ, 16'h01ff, 1'b0, 8'h00, 1'b0, 8'hff);
    acc(FOL_CMD_READ, 16'h0200, 1'b0, 8'h00, 1'b0, pat(16'h0200));
    chk_opts(OPT0);
    $display("test access done");
    reload();
    chk_opts(8'hff);
    acc(FOL_CMD_PROG, 16'h0500, 1'b0, 8'h00, 1'b0, 8'h00);
    acc(FOL_CMD_READ, 16'h0500, 1'b1, 8'h00, 1'b0, 8'h00);
    acc(FOL_CMD_PROG, FOL_OPT0_ADDR, 1'b0, 8'h37, 1'b0, 8'h00);
    chk_opts(8'hff);
    reload();
    chk_opts(8'h37);
    acc(FOL_CMD_PROG, 16'h0900, 1'b0, 8'h00, 1'b1, 8'h00);
    acc(FOL_CMD_ERASE, 16'h0900, 1'b0, 8'h00, 1'b1, 8'h00);
    $display("test option reload done");
    complete_run();
  end
endmodule : fol_loader_bench
`default_nettype wire
